// >>> fec_config.sv
// front-end pin control and clear channel assessment configuration
`include "fec_params.svh"

module fec_config #(
  parameter logic [15:0] CCA_CYCLES =
    16'(`FEC_CCA_TIME_NS / `FEC_CLK_PERIOD_NS)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [9:0] regAddr,
  input wire logic [7:0] regWdata,
  output logic [7:0] regRdata,
  input wire logic inRxState,
  input wire logic inTxState,
  input wire logic [7:0] rssiReadback,
  input wire logic ccaMeasureDone,
  input wire logic userRxLevel,
  input wire logic userTxLevel,
  input wire logic userExtPaBias,
  output logic receiveFrontEndPin,
  output logic transmitFrontEndPin,
  output logic extPaEnable,
  output logic ampRampdownSelect,
  output logic ccaResult,
  output logic ccaComplete,
  output logic pendingCca
);

  function automatic logic hit(input logic [9:0] a, input logic [9:0] t);
    hit = (a == t);
  endfunction

  logic [7:0] frontEndCtrl_q;
  logic [7:0] ccaThreshold_q;
  logic [7:0] ccaMode_q;
  logic [7:0] regRdata_q;
  logic [7:0] regRdata_d;
  logic ccaResult_q;
  logic ccaComplete_q;
  logic pendingCca_q;
  logic rxPrev_q;
  logic rxEntry;
  logic timerRun;
  logic timerExpire;
  logic ccaDone;
  logic clearCca;
  logic contOn;
  logic autoOn;
  fec_pkg::fec_cca_state_type state_q;
  fec_pkg::fec_cca_state_type state_d;

  assign contOn = ccaMode_q[`FEC_CONT_BIT];
  assign autoOn = ccaMode_q[`FEC_AUTO_BIT];

  // front_end_control, reserved bits held at zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frontEndCtrl_q <= `FEC_FRONT_END_RST;
    end else if (regWrite && hit(regAddr, `FEC_ADDR_FRONT_END)) begin
      frontEndCtrl_q <= regWdata & `FEC_FRONT_END_MASK;
    end
  end

  // clear_channel_threshold, all eight bits signed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccaThreshold_q <= `FEC_THRESHOLD_RST;
    end else if (regWrite && hit(regAddr, `FEC_ADDR_THRESHOLD)) begin
      ccaThreshold_q <= regWdata;
    end
  end

  // clear_channel_mode, reserved bits held at zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccaMode_q <= `FEC_CCA_MODE_RST;
    end else if (regWrite && hit(regAddr, `FEC_ADDR_CCA_MODE)) begin
      ccaMode_q <= regWdata & `FEC_CCA_MODE_MASK;
    end
  end

  assign ampRampdownSelect = frontEndCtrl_q[`FEC_RAMP_BIT];

  // pin selection per front-end line
  fec_pin_select u_rx_pin (
    .clk(clk),
    .nrst(nrst),
    .autoEn(frontEndCtrl_q[`FEC_RX_AUTO_BIT]),
    .inState(inRxState),
    .userLevel(userRxLevel),
    .pin(receiveFrontEndPin)
  );

  fec_pin_select u_tx_pin (
    .clk(clk),
    .nrst(nrst),
    .autoEn(frontEndCtrl_q[`FEC_TX_AUTO_BIT]),
    .inState(inTxState),
    .userLevel(userTxLevel),
    .pin(transmitFrontEndPin)
  );

  fec_pin_select u_pa_pin (
    .clk(clk),
    .nrst(nrst),
    .autoEn(frontEndCtrl_q[`FEC_PA_AUTO_BIT]),
    .inState(inTxState),
    .userLevel(userExtPaBias),
    .pin(extPaEnable)
  );

  // rx entry detect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxPrev_q <= 1'b0;
    end else begin
      rxPrev_q <= inRxState;
    end
  end

  assign rxEntry = inRxState && !rxPrev_q;

  // periodic and automatic scheduling
  always_comb begin
    state_d = state_q;
    case (state_q)
      fec_pkg::FEC_IDLE: begin
        if (contOn) begin
          state_d = fec_pkg::FEC_CONT;
        end else if (autoOn && rxEntry) begin
          state_d = fec_pkg::FEC_AUTO;
        end
      end
      fec_pkg::FEC_AUTO: begin
        if (contOn) begin
          state_d = fec_pkg::FEC_CONT;
        end else if (timerExpire || !autoOn || !inRxState) begin
          state_d = fec_pkg::FEC_IDLE;
        end
      end
      fec_pkg::FEC_CONT: begin
        if (!contOn) begin
          state_d = fec_pkg::FEC_IDLE;
        end
      end
      default: begin
        state_d = fec_pkg::FEC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= fec_pkg::FEC_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  assign timerRun = (state_q != fec_pkg::FEC_IDLE);

  fec_cca_timer #(
    .CYCLES(CCA_CYCLES)
  ) u_timer (
    .clk(clk),
    .nrst(nrst),
    .run(timerRun),
    .expire(timerExpire)
  );

  assign ccaDone = ccaMeasureDone || timerExpire;

  // signed comparison against threshold on each completion
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccaResult_q <= 1'b0;
    end else if (ccaDone) begin
      ccaResult_q <= $signed(rssiReadback) < $signed(ccaThreshold_q);
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ccaComplete_q <= 1'b0;
    end else begin
      ccaComplete_q <= ccaDone;
    end
  end

  // pending event, set wins over a same-cycle clear
  assign clearCca = regWrite && hit(regAddr, `FEC_ADDR_PENDING)
    && regWdata[`FEC_PEND_CCA_BIT];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pendingCca_q <= 1'b0;
    end else if (ccaDone) begin
      pendingCca_q <= 1'b1;
    end else if (clearCca) begin
      pendingCca_q <= 1'b0;
    end
  end

  assign ccaResult = ccaResult_q;
  assign ccaComplete = ccaComplete_q;
  assign pendingCca = pendingCca_q;

  // read data, unmapped addresses read zero
  always_comb begin
    regRdata_d = 8'h00;
    if (hit(regAddr, `FEC_ADDR_FRONT_END)) begin
      regRdata_d = frontEndCtrl_q;
    end else if (hit(regAddr, `FEC_ADDR_THRESHOLD)) begin
      regRdata_d = ccaThreshold_q;
    end else if (hit(regAddr, `FEC_ADDR_CCA_MODE)) begin
      regRdata_d = ccaMode_q;
    end else if (hit(regAddr, `FEC_ADDR_RSSI)) begin
      regRdata_d = rssiReadback;
    end else if (hit(regAddr, `FEC_ADDR_PENDING)) begin
      regRdata_d = {7'h00, pendingCca_q};
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      regRdata_q <= 8'h00;
    end else if (regRead) begin
      regRdata_q <= regRdata_d;
    end
  end

  assign regRdata = regRdata_q;

  // checks
  logic [15:0] periodCnt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      periodCnt_q <= 16'h0000;
    end else if (!timerRun || timerExpire) begin
      periodCnt_q <= 16'h0000;
    end else begin
      periodCnt_q <= periodCnt_q + 16'h0001;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_ramp_write: assert property (
    regWrite && hit(regAddr, `FEC_ADDR_FRONT_END)
    |=> ampRampdownSelect == $past(regWdata[`FEC_RAMP_BIT]))
    else $error("ramp select not taken from write");

  a_rx_pin: assert property (
    1'b1 |=> receiveFrontEndPin == ($past(frontEndCtrl_q[`FEC_RX_AUTO_BIT])
      ? $past(inRxState) : $past(userRxLevel)))
    else $error("receive pin wrong source");

  a_tx_pin: assert property (
    1'b1 |=> transmitFrontEndPin == ($past(frontEndCtrl_q[`FEC_TX_AUTO_BIT])
      ? $past(inTxState) : $past(userTxLevel)))
    else $error("transmit pin wrong source");

  a_pa_auto: assert property (
    frontEndCtrl_q[`FEC_PA_AUTO_BIT] && inTxState
    && $past(frontEndCtrl_q[`FEC_PA_AUTO_BIT])
    |=> extPaEnable)
    else $error("external amp not enabled in transmit");

  a_thresh_hold: assert property (
    !(regWrite && hit(regAddr, `FEC_ADDR_THRESHOLD)) |=> $stable(ccaThreshold_q))
    else $error("threshold changed without write");

  a_result_cmp: assert property (
    ccaDone |=> ccaResult ==
      ($signed($past(rssiReadback)) < $signed($past(ccaThreshold_q))))
    else $error("clear channel result wrong");

  a_cont_period: assert property (
    timerExpire |-> periodCnt_q == CCA_CYCLES - 16'h0001)
    else $error("clear channel period wrong");

  a_cont_repeat: assert property (
    state_q == fec_pkg::FEC_CONT && contOn && timerExpire
    |=> pendingCca && state_q == fec_pkg::FEC_CONT)
    else $error("continuous mode stopped after event");

  a_auto_once: assert property (
    state_q == fec_pkg::FEC_AUTO && !contOn && timerExpire
    |=> state_q == fec_pkg::FEC_IDLE && pendingCca)
    else $error("automatic event not single");

  a_done_pulse: assert property (
    ccaDone |=> ccaComplete && pendingCca)
    else $error("completion not flagged");

  a_pend_hold: assert property (
    pendingCca && !clearCca |=> pendingCca)
    else $error("pending bit lost without written one");

  a_pend_clear: assert property (
    clearCca && !ccaDone |=> !pendingCca)
    else $error("pending bit not cleared");

  c_cont_event: cover property (
    state_q == fec_pkg::FEC_CONT && timerExpire);

  c_auto_event: cover property (
    state_q == fec_pkg::FEC_AUTO && timerExpire);

  c_set_clear: cover property (ccaDone && clearCca);

  c_rx_auto_pin: cover property (
    frontEndCtrl_q[`FEC_RX_AUTO_BIT] && receiveFrontEndPin);

endmodule

// >>> fec_params.svh
// constants for the front-end and clear channel configuration block
`ifndef FEC_PARAMS_SVH
`define FEC_PARAMS_SVH

// register addresses on the serial control port
`define FEC_ADDR_FRONT_END 10'h100
`define FEC_ADDR_THRESHOLD 10'h105
`define FEC_ADDR_CCA_MODE 10'h106
`define FEC_ADDR_RSSI 10'h30C
`define FEC_ADDR_PENDING 10'h3CC

// front_end_control fields
`define FEC_RAMP_BIT 7
`define FEC_RX_AUTO_BIT 4
`define FEC_TX_AUTO_BIT 3
`define FEC_PA_AUTO_BIT 2
`define FEC_FRONT_END_MASK 8'h9C
`define FEC_FRONT_END_RST 8'h00

// clear_channel_threshold, signed dBm
`define FEC_THRESHOLD_RST 8'hAB

// clear_channel_mode fields
`define FEC_CONT_BIT 2
`define FEC_AUTO_BIT 1
`define FEC_CCA_MODE_MASK 8'h06
`define FEC_CCA_MODE_RST 8'h00

// pending_event_upper fields
`define FEC_PEND_CCA_BIT 0
`define FEC_PENDING_RST 8'h00

// timing
`define FEC_CLK_PERIOD_NS 25
`define FEC_CCA_TIME_NS 128000

`endif

// >>> fec_pkg.sv
// types shared by the front-end and clear channel configuration block
package fec_pkg;

  typedef enum logic [1:0] {
    FEC_IDLE = 2'b00,
    FEC_AUTO = 2'b01,
    FEC_CONT = 2'b11
  } fec_cca_state_type;

endpackage

// >>> fec_pin_select.sv
// registered front-end pin: radio state in automatic mode, else user level
module fec_pin_select (
  input wire logic clk,
  input wire logic nrst,
  input wire logic autoEn,
  input wire logic inState,
  input wire logic userLevel,
  output logic pin
);

  logic pin_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pin_q <= 1'b0;
    end else if (autoEn) begin
      pin_q <= inState;
    end else begin
      pin_q <= userLevel;
    end
  end

  assign pin = pin_q;

endmodule

// >>> fec_cca_timer.sv
// free period counter: pulses expire every CYCLES clocks while run is high
`include "fec_params.svh"

module fec_cca_timer #(
  parameter logic [15:0] CYCLES =
    16'(`FEC_CCA_TIME_NS / `FEC_CLK_PERIOD_NS)
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic run,
  output logic expire
);

  logic [15:0] count_q;
  logic [15:0] count_d;

  always_comb begin
    count_d = count_q + 16'h0001;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= 16'h0000;
    end else if (!run || expire) begin
      count_q <= 16'h0000;
    end else begin
      count_q <= count_d;
    end
  end

  assign expire = run && (count_q == CYCLES - 16'h0001);

endmodule

// >>> fec_front_end_model.sv
// behavioural external front end: measured level and measurement end
module fec_front_end_model (
  input wire logic [7:0] level,
  input wire logic measure,
  output logic [7:0] rssiReadback,
  output logic ccaMeasureDone
);
  timeunit 1ns;
  timeprecision 1ps;
  assign rssiReadback = level;
  assign ccaMeasureDone = measure;
endmodule

// >>> front_end_and_cca_config_bench.sv
// self-checking bench for the front-end and clear channel block
module front_end_and_cca_config_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] N = 16'h000C;
  logic clk, nrst, regWrite, regRead, inRxState, inTxState;
  logic userRxLevel, userTxLevel, userExtPaBias, measure, ccaMeasureDone;
  logic [9:0] regAddr;
  logic [7:0] regWdata, regRdata, rssiReadback, level, thr, mode;
  logic receiveFrontEndPin, transmitFrontEndPin, extPaEnable;
  logic ampRampdownSelect, ccaResult, ccaComplete, pendingCca;
  int fails = 0;
  int numChecks = 0;
  integer seed = 99319;
  int k, t, c;
  logic [4:0] r;

  fec_config #(.CCA_CYCLES(N)) dut_u (
    .clk(clk), .nrst(nrst), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .inRxState(inRxState), .inTxState(inTxState),
    .rssiReadback(rssiReadback), .ccaMeasureDone(ccaMeasureDone),
    .userRxLevel(userRxLevel), .userTxLevel(userTxLevel),
    .userExtPaBias(userExtPaBias),
    .receiveFrontEndPin(receiveFrontEndPin),
    .transmitFrontEndPin(transmitFrontEndPin),
    .extPaEnable(extPaEnable), .ampRampdownSelect(ampRampdownSelect),
    .ccaResult(ccaResult), .ccaComplete(ccaComplete),
    .pendingCca(pendingCca)
  );

  fec_front_end_model fe_u (
    .level(level), .measure(measure),
    .rssiReadback(rssiReadback), .ccaMeasureDone(ccaMeasureDone)
  );

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", numChecks, fails);
    if (fails == 0 && numChecks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    @(negedge clk);
    regWrite = 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input logic [9:0] a, input logic [7:0] exp);
    regRead = 1'b1;
    regAddr = a;
    @(negedge clk);
    regRead = 1'b0;
    chk(regRdata, exp);
    @(negedge clk);
  endtask

  // waits for a completion pulse, counting falling edges
  task automatic waitDone(input int lim);
    c = 0;
    while (ccaComplete !== 1'b1 && c < lim) begin
      @(negedge clk);
      c++;
    end
  endtask

  function automatic logic clearOf(input logic [7:0] r, input logic [7:0] h);
    return $signed(r) < $signed(h);
  endfunction

  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  initial begin
    {nrst, regWrite, regRead, inRxState, inTxState, measure} = 6'h00;
    {userRxLevel, userTxLevel, userExtPaBias} = 3'h0;
    regAddr = 10'h000;
    regWdata = 8'h00;
    level = 8'h00;
    repeat (5) @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    rdc(10'h100, 8'h00);
    rdc(10'h105, 8'hAB);
    rdc(10'h106, 8'h00);
    rdc(10'h3CC, 8'h00);
    wr(10'h100, 8'h9C);
    rdc(10'h100, 8'h9C);
    chk(ampRampdownSelect, 1'b1);
    wr(10'h106, 8'h06);
    rdc(10'h106, 8'h06);
    wr(10'h106, 8'h00);
    level = 8'hC5;
    wr(10'h30C, 8'h11);
    rdc(10'h30C, 8'hC5);
    rdc(10'h3FF, 8'h00);
    $display("register test done");
    for (k = 0; k < 16; k++) begin
      {inRxState, inTxState} = 2'h0;
      mode = 8'($random(seed)) & 8'h9C;
      wr(10'h100, mode);
      for (t = 0; t < 8; t++) begin
        r = 5'($random(seed));
        {inRxState, inTxState, userRxLevel, userTxLevel, userExtPaBias} =
          {r[4], r[3] & ~r[4], r[2:0]};
        @(negedge clk);
        chk(receiveFrontEndPin, mode[4] ? inRxState : userRxLevel);
        chk(transmitFrontEndPin, mode[3] ? inTxState : userTxLevel);
        chk(extPaEnable, mode[2] ? inTxState : userExtPaBias);
        chk(ampRampdownSelect, mode[7]);
      end
    end
    {inRxState, inTxState} = 2'h0;
    wr(10'h100, 8'h00);
    $display("pin test done");
    for (k = 0; k < 12; k++) begin
      thr = 8'($random(seed));
      level = (k == 0) ? thr : 8'($random(seed));
      wr(10'h105, thr);
      rdc(10'h105, thr);
      measure = 1'b1;
      @(negedge clk);
      measure = 1'b0;
      waitDone(3);
      chk(c <= 1, 1'b1);
      chk(ccaResult, clearOf(level, thr));
      chk(pendingCca, 1'b1);
      wr(10'h3CC, 8'hFE);
      chk(pendingCca, 1'b1);
      wr(10'h3CC, 8'h01);
      chk(pendingCca, 1'b0);
    end
    measure = 1'b1;
    regWrite = 1'b1;
    regAddr = 10'h3CC;
    regWdata = 8'h01;
    @(negedge clk);
    {measure, regWrite} = 2'h0;
    @(negedge clk);
    chk(pendingCca, 1'b1);
    wr(10'h3CC, 8'h01);
    chk(pendingCca, 1'b0);
    $display("compare test done");
    wr(10'h106, 8'h02);
    inRxState = 1'b1;
    waitDone(4 * N);
    chk(c >= N && c <= N + 3, 1'b1);
    chk(ccaResult, clearOf(level, thr));
    @(negedge clk);
    waitDone(3 * N);
    chk(ccaComplete, 1'b0);
    inRxState = 1'b0;
    wr(10'h106, 8'h00);
    $display("auto test done");
    level = 8'h7F;
    wr(10'h106, 8'h04);
    waitDone(3 * N);
    chk(ccaResult, clearOf(level, thr));
    @(negedge clk);
    waitDone(3 * N);
    chk(c, N - 1);
    wr(10'h106, 8'h00);
    $display("continuous test done");
    nrst = 1'b0;
    @(negedge clk);
    nrst = 1'b1;
    @(negedge clk);
    chk(pendingCca, 1'b0);
    rdc(10'h105, 8'hAB);
    $display("reset test done");
    report_and_stop();
  end
endmodule
